// file: logic/stereo_adc_cfg.svh
`ifndef STEREO_ADC_CFG_SVH
`define STEREO_ADC_CFG_SVH

// ==========================================================
// register offsets
`define REG_PART_IDENTITY 8'h01
`define REG_FIRST_RW 8'h02
`define REG_LAST_RW 8'h06
`define REG_COUNT 5

// ==========================================================
// reset values
`define RST_POWER_CONTROL_ONE 8'h00
`define RST_MIC_POWER_AND_SPEED 8'hAE
`define RST_SERIAL_INTERFACE_CONTROL 8'h00
`define RST_MIC_GAIN_BIAS_CONTROL 8'h00
`define RST_CONVERTER_FILTER_RAMP 8'hA0

// ==========================================================
// power_control_one fields
`define PC1_GLOBAL_PDN 0
`define PC1_CONV_PDN_A 1
`define PC1_CONV_PDN_B 2
`define PC1_AMP_PDN_A 3
`define PC1_AMP_PDN_B 4

// ==========================================================
// mic_power_and_speed fields
`define MPS_HALVE 0
`define MPS_BIAS_PDN 1
`define MPS_PREAMP_PDN_A 2
`define MPS_PREAMP_PDN_B 3
`define MPS_FLOAT 4
`define MPS_SPEED_LO 5
`define MPS_SPEED_HI 6
`define MPS_AUTO 7

// ==========================================================
// serial_interface_control fields
`define SIC_MIX 0
`define SIC_ROUTE 1
`define SIC_FORMAT 2
`define SIC_MASTER 6

// ==========================================================
// mic_gain_bias_control fields
`define MGB_PREAMP_GAIN_A 0
`define MGB_PREAMP_GAIN_B 1
`define MGB_LEVEL_LO 2
`define MGB_LEVEL_HI 3
`define MGB_BIAS_SEL 4
`define MGB_BOOST_A 5
`define MGB_BOOST_B 6
`define MGB_GANG 7

`endif

// file: logic/stereo_adc_pkg.sv
package stereo_adc_pkg;

  // ==========================================================
  // speed modes, in field order 00..11
  typedef enum logic [1:0] {
    double_rate,
    single_rate,
    half_rate,
    quarter_rate
  } speed_t;

  // ==========================================================
  // analog path into each converter
  typedef enum logic [2:0] {
    path_in1_amp,
    path_in2_amp,
    path_in3_amp,
    path_in3_preamp_amp,
    path_in1_direct,
    path_in2_direct,
    path_in3_direct,
    path_reserved
  } path_t;

  typedef enum logic [1:0] {
    route_raw,
    route_processed,
    route_reserved
  } route_t;

  // ==========================================================
  // channel pairs
  typedef struct packed {
    logic [23:0] b;
    logic [23:0] a;
  } sample_pair_t;

  typedef struct packed {
    logic [4:0] b;
    logic [4:0] a;
  } gain_pair_t;

  typedef struct packed {
    logic [7:0] b;
    logic [7:0] a;
  } att_pair_t;

endpackage : stereo_adc_pkg

// file: logic/stereo_adc_control_regs.sv
`timescale 1ns/1ps
`include "stereo_adc_cfg.svh"
// Functional notes
// - registers read/write, identity read-only, defaults on reset
// - identity holds part code and revision
// - channel power-down only after both down
// - global power-down keeps register contents
// - amp bit and input select pick path
// - auto-detect in slave overrides speed field
// - speed field picks quarter/half/single/double rate
// - float: master floats all, slave data only
// - preamp and bias power-down default set
// - clock halving, ignored slave without auto
// - role bit: zero slave, one master
// - format bit: zero left-justified, one I2S
// - route raw or processed samples out
// - mix bit sends (A-B)/2 on both
// - ganged volume: channel A governs both
// - digital boost adds 20 dB per channel
// - bias pin and level selection
// - preamp gain sixteen or thirty-two dB
module stereo_adc_control_regs #(
  parameter logic [4:0] PART_CODE = 5'h0A, // arbitrary value
  parameter logic [2:0] SILICON_REVISION = 3'h2 // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire stereo_adc_pkg::speed_t i_detected_speed,
  input wire logic i_processing_engine_on,
  input wire logic [3:0] i_chan_input_select,
  input wire stereo_adc_pkg::gain_pair_t i_amp_gain,
  input wire stereo_adc_pkg::att_pair_t i_attenuation,
  input wire logic [1:0] i_level_ctrl_on,
  input wire stereo_adc_pkg::sample_pair_t i_samples,
  input wire logic i_sample_valid,
  output logic [7:0] o_rdata,
  output logic o_low_power,
  output logic [1:0] o_chan_converter_off,
  output logic [1:0] o_chan_amp_off,
  output logic [1:0] o_chan_mute,
  output stereo_adc_pkg::path_t o_path_a,
  output stereo_adc_pkg::path_t o_path_b,
  output stereo_adc_pkg::speed_t o_speed,
  output logic o_master_clock_halve,
  output logic o_bit_clock_oe_n,
  output logic o_frame_clock_oe_n,
  output logic o_serial_data_oe_n,
  output logic o_master_mode,
  output logic o_frame_format_i2s,
  output stereo_adc_pkg::route_t o_output_route,
  output logic [1:0] o_chan_preamp_off,
  output logic o_bias_off,
  output logic [1:0] o_chan_preamp_high_gain,
  output logic [1:0] o_chan_digital_boost,
  output logic o_bias_pin_second,
  output logic [1:0] o_bias_level,
  output stereo_adc_pkg::gain_pair_t o_amp_gain,
  output stereo_adc_pkg::att_pair_t o_attenuation,
  output logic [1:0] o_level_ctrl_on,
  output stereo_adc_pkg::sample_pair_t o_samples,
  output logic o_sample_valid
);

  // ==========================================================
  // address decode
  function automatic logic rw_hit(input logic [7:0] addr);
    rw_hit = (addr >= `REG_FIRST_RW) && (addr <= `REG_LAST_RW);
  endfunction : rw_hit

  function automatic logic [2:0] rw_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - `REG_FIRST_RW;
    rw_index = diff[2:0];
  endfunction : rw_index

  function automatic stereo_adc_pkg::path_t path_of(input logic amp_off, input logic [1:0] sel);
    path_of = stereo_adc_pkg::path_t'({amp_off, sel});
  endfunction : path_of

  logic [7:0] regs_q [`REG_COUNT];
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  wire logic wr_hit = i_wr && rw_hit(i_addr);
  wire logic [2:0] wr_idx = rw_index(i_addr);
  wire logic [2:0] rd_idx = rw_index(i_addr);
  wire logic id_hit = (i_addr == `REG_PART_IDENTITY);

  // ==========================================================
  // register storage
  // reserved bits are stored like any other, so software reads back what it wrote
  genvar g;
  generate
    for (g = 0; g < `REG_COUNT; g++)
    begin : g_reg
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          case (g)
            0: regs_q[g] <= `RST_POWER_CONTROL_ONE;
            1: regs_q[g] <= `RST_MIC_POWER_AND_SPEED;
            2: regs_q[g] <= `RST_SERIAL_INTERFACE_CONTROL;
            3: regs_q[g] <= `RST_MIC_GAIN_BIAS_CONTROL;
            default: regs_q[g] <= `RST_CONVERTER_FILTER_RAMP;
          endcase
        end
        else if (wr_hit && (wr_idx == 3'(g)))
        begin
          regs_q[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // ==========================================================
  // read path: identity is constant, unmapped reads zero
  assign rdata_d = !i_rd ? 8'h00 :
                   id_hit ? {PART_CODE, SILICON_REVISION} :
                   rw_hit(i_addr) ? regs_q[rd_idx] : 8'h00;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end
  assign o_rdata = rdata_q;

  // ==========================================================
  // field views
  wire logic [7:0] pc1 = regs_q[0];
  wire logic [7:0] mps = regs_q[1];
  wire logic [7:0] sic = regs_q[2];
  wire logic [7:0] mgb = regs_q[3];
  wire logic global_power_down = pc1[`PC1_GLOBAL_PDN];
  wire logic [1:0] chan_converter_power_down = {pc1[`PC1_CONV_PDN_B], pc1[`PC1_CONV_PDN_A]};
  wire logic [1:0] chan_amp_power_down = {pc1[`PC1_AMP_PDN_B], pc1[`PC1_AMP_PDN_A]};
  wire logic auto_detect = mps[`MPS_AUTO];
  wire logic master = sic[`SIC_MASTER];
  wire logic serial_port_float = mps[`MPS_FLOAT];
  wire logic differential_mix_enable = sic[`SIC_MIX];
  wire logic output_route_select = sic[`SIC_ROUTE];
  wire logic ganged_volume = mgb[`MGB_GANG];

  // ==========================================================
  // power-down sequencing
  // a lone channel bit after full power-up only mutes; real power saving
  // needs both channels down first, then the state holds per channel
  wire logic conv_all_down = global_power_down || (&chan_converter_power_down);
  wire logic amp_all_down = global_power_down || (&chan_amp_power_down);
  logic [1:0] conv_off_d;
  logic [1:0] conv_off_q;
  logic [1:0] amp_off_d;
  logic [1:0] amp_off_q;
  logic [1:0] mute_d;
  logic [1:0] mute_q;

  generate
    for (g = 0; g < 2; g++)
    begin : g_chan
      assign conv_off_d[g] = conv_all_down ||
        (conv_off_q[g] && chan_converter_power_down[g]);
      assign amp_off_d[g] = amp_all_down ||
        (amp_off_q[g] && chan_amp_power_down[g]);
      assign mute_d[g] = (chan_converter_power_down[g] && !conv_off_d[g]) ||
        (chan_amp_power_down[g] && !amp_off_d[g]);
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      conv_off_q <= 2'h0;
      amp_off_q <= 2'h0;
      mute_q <= 2'h0;
    end
    else
    begin
      conv_off_q <= conv_off_d;
      amp_off_q <= amp_off_d;
      mute_q <= mute_d;
    end
  end
  assign o_chan_converter_off = conv_off_q;
  assign o_chan_amp_off = amp_off_q;
  assign o_chan_mute = mute_q;

  // ==========================================================
  // path, speed, clocking and serial port pins
  wire stereo_adc_pkg::path_t path_a_d = path_of(chan_amp_power_down[0], i_chan_input_select[1:0]);
  wire stereo_adc_pkg::path_t path_b_d = path_of(chan_amp_power_down[1], i_chan_input_select[3:2]);
  wire logic auto_applies = auto_detect && !master;
  wire stereo_adc_pkg::speed_t speed_d = auto_applies ? i_detected_speed :
    stereo_adc_pkg::speed_t'(mps[`MPS_SPEED_HI:`MPS_SPEED_LO]);
  wire logic halve_d = mps[`MPS_HALVE] && (master || auto_detect);
  // clocks are inputs in slave mode, so only the master may drive them
  wire logic clock_oe_n_d = !(master && !serial_port_float);
  wire logic data_oe_n_d = serial_port_float;
  wire stereo_adc_pkg::route_t route_d = !output_route_select ? stereo_adc_pkg::route_raw :
    (i_processing_engine_on ? stereo_adc_pkg::route_processed : stereo_adc_pkg::route_reserved);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_path_a <= stereo_adc_pkg::path_in1_amp;
      o_path_b <= stereo_adc_pkg::path_in1_amp;
      o_speed <= stereo_adc_pkg::single_rate;
      o_master_clock_halve <= 1'b0;
      o_bit_clock_oe_n <= 1'b1;
      o_frame_clock_oe_n <= 1'b1;
      o_serial_data_oe_n <= 1'b0;
      o_output_route <= stereo_adc_pkg::route_raw;
    end
    else
    begin
      o_path_a <= path_a_d;
      o_path_b <= path_b_d;
      o_speed <= speed_d;
      o_master_clock_halve <= halve_d;
      o_bit_clock_oe_n <= clock_oe_n_d;
      o_frame_clock_oe_n <= clock_oe_n_d;
      o_serial_data_oe_n <= data_oe_n_d;
      o_output_route <= route_d;
    end
  end

  // ==========================================================
  // straight control outputs
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_low_power <= 1'b0;
      o_master_mode <= 1'b0;
      o_frame_format_i2s <= 1'b0;
      o_chan_preamp_off <= 2'h3;
      o_bias_off <= 1'b1;
      o_chan_preamp_high_gain <= 2'h0;
      o_chan_digital_boost <= 2'h0;
      o_bias_pin_second <= 1'b0;
      o_bias_level <= 2'h0;
    end
    else
    begin
      o_low_power <= global_power_down;
      o_master_mode <= master;
      o_frame_format_i2s <= sic[`SIC_FORMAT];
      o_chan_preamp_off <= {mps[`MPS_PREAMP_PDN_B], mps[`MPS_PREAMP_PDN_A]};
      o_bias_off <= mps[`MPS_BIAS_PDN];
      o_chan_preamp_high_gain <= {mgb[`MGB_PREAMP_GAIN_B], mgb[`MGB_PREAMP_GAIN_A]};
      o_chan_digital_boost <= {mgb[`MGB_BOOST_B], mgb[`MGB_BOOST_A]};
      o_bias_pin_second <= mgb[`MGB_BIAS_SEL];
      o_bias_level <= mgb[`MGB_LEVEL_HI:`MGB_LEVEL_LO];
    end
  end

  // ==========================================================
  // ganged volume and sample mixing
  wire stereo_adc_pkg::gain_pair_t gain_d = ganged_volume ?
    {i_amp_gain.a, i_amp_gain.a} : i_amp_gain;
  wire stereo_adc_pkg::att_pair_t att_d = ganged_volume ?
    {i_attenuation.a, i_attenuation.a} : i_attenuation;
  wire logic [1:0] level_d = ganged_volume ? {2{i_level_ctrl_on[0]}} : i_level_ctrl_on;
  // sign-extend before subtracting so the halved difference never overflows
  wire logic [24:0] diff_full = {i_samples.a[23], i_samples.a} - {i_samples.b[23], i_samples.b};
  wire logic [23:0] diff_half = diff_full[24:1];
  wire stereo_adc_pkg::sample_pair_t samples_d = differential_mix_enable ?
    {diff_half, diff_half} : i_samples;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_amp_gain <= '0;
      o_attenuation <= '0;
      o_level_ctrl_on <= 2'h0;
      o_samples <= '0;
      o_sample_valid <= 1'b0;
    end
    else
    begin
      o_amp_gain <= gain_d;
      o_attenuation <= att_d;
      o_level_ctrl_on <= level_d;
      o_sample_valid <= i_sample_valid;
      if (i_sample_valid)
        o_samples <= samples_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_id_read_value: assert property (
    (i_rd && id_hit) |=> (o_rdata == {PART_CODE, SILICON_REVISION}))
    else $error("identity read wrong");
  a_write_read_back: assert property (
    (i_wr && rw_hit(i_addr)) ##1 (i_rd && (i_addr == $past(i_addr)))
    |=> (o_rdata == $past(i_wdata, 2)))
    else $error("register read back differs from write");
  a_unmapped_read_zero: assert property (
    (i_rd && !id_hit && !rw_hit(i_addr)) |=> (o_rdata == 8'h00))
    else $error("unmapped read not zero");
  a_global_low_power: assert property (
    global_power_down |=> (o_low_power && (o_chan_converter_off == 2'h3)))
    else $error("global power-down not applied");
  a_lone_bit_mutes: assert property (
    (!conv_all_down && !conv_off_q[0] && chan_converter_power_down[0])
    |=> (o_chan_mute[0] && !o_chan_converter_off[0]))
    else $error("single channel bit did not only mute");
  a_auto_speed: assert property (
    auto_applies |=> (o_speed == $past(i_detected_speed)))
    else $error("auto speed not used");
  a_halve_ignored: assert property (
    (!master && !auto_detect) |=> !o_master_clock_halve)
    else $error("clock halve not ignored");
  a_slave_float: assert property (
    (serial_port_float && !master) |=> (o_bit_clock_oe_n && o_frame_clock_oe_n
    && o_serial_data_oe_n))
    else $error("slave float wrong");
  a_mix_samples: assert property (
    (i_sample_valid && differential_mix_enable)
    |=> (o_sample_valid && (o_samples.a == $past(diff_half)) && (o_samples.b == o_samples.a)))
    else $error("differential mix wrong");
  a_gang_gain: assert property (
    ganged_volume |=> ((o_amp_gain.b == $past(i_amp_gain.a))
    && (o_attenuation.b == $past(i_attenuation.a))))
    else $error("ganged volume not applied");
  a_route_reserved: assert property (
    (output_route_select && !i_processing_engine_on)
    |=> (o_output_route == stereo_adc_pkg::route_reserved))
    else $error("route select wrong");
  a_read_idle_zero: assert property (
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data not zero outside read");
  a_both_down_off: assert property (
    (&chan_converter_power_down) |=> (o_chan_converter_off == 2'h3))
    else $error("both channel bits did not power down");
  a_split_stays_off: assert property (
    (conv_off_q[0] && chan_converter_power_down[0]) |=> o_chan_converter_off[0])
    else $error("powered-down channel woke while its bit set");
  a_speed_field_used: assert property (
    !auto_applies
    |=> (o_speed == stereo_adc_pkg::speed_t'($past(mps[`MPS_SPEED_HI:`MPS_SPEED_LO]))))
    else $error("speed field not applied");
  a_master_drives_pins: assert property (
    (master && !serial_port_float)
    |=> (!o_bit_clock_oe_n && !o_frame_clock_oe_n && !o_serial_data_oe_n))
    else $error("master not driving serial pins");
  a_master_float_all: assert property (
    (master && serial_port_float)
    |=> (o_bit_clock_oe_n && o_frame_clock_oe_n && o_serial_data_oe_n))
    else $error("master float did not release all pins");

  c_channel_sequence: cover property (
    global_power_down ##[1:20] (chan_converter_power_down[0] && !global_power_down));
  c_master_float: cover property (master && serial_port_float ##1 o_bit_clock_oe_n);
  c_mix_sample: cover property (i_sample_valid && differential_mix_enable);
  c_processed_route: cover property (o_output_route == stereo_adc_pkg::route_processed);
  c_write_then_read: cover property (i_wr ##1 i_rd);

endmodule : stereo_adc_control_regs

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // stimulus and observation
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  stereo_adc_pkg::speed_t i_detected_speed = stereo_adc_pkg::quarter_rate;
  logic i_processing_engine_on = 1'b0;
  logic [3:0] i_chan_input_select = 4'h9;
  stereo_adc_pkg::gain_pair_t i_amp_gain = {5'h07, 5'h1A};
  stereo_adc_pkg::att_pair_t i_attenuation = {8'h33, 8'hC4};
  logic [1:0] i_level_ctrl_on = 2'h1;
  stereo_adc_pkg::sample_pair_t i_samples = '0;
  logic i_sample_valid = 1'b0;
  logic [7:0] o_rdata;
  logic o_low_power, o_master_clock_halve, o_bit_clock_oe_n, o_frame_clock_oe_n;
  logic o_serial_data_oe_n, o_master_mode, o_frame_format_i2s, o_bias_off;
  logic o_bias_pin_second, o_sample_valid;
  logic [1:0] o_chan_converter_off, o_chan_amp_off, o_chan_mute, o_chan_preamp_off;
  logic [1:0] o_chan_preamp_high_gain, o_chan_digital_boost, o_bias_level, o_level_ctrl_on;
  stereo_adc_pkg::path_t o_path_a, o_path_b;
  stereo_adc_pkg::speed_t o_speed;
  stereo_adc_pkg::route_t o_output_route;
  stereo_adc_pkg::gain_pair_t o_amp_gain;
  stereo_adc_pkg::att_pair_t o_attenuation;
  stereo_adc_pkg::sample_pair_t o_samples;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] id_v = {5'h15, 3'h5}; // arbitrary identity values

  always #5 i_clk = ~i_clk;

  stereo_adc_control_regs #(.PART_CODE(5'h15), .SILICON_REVISION(3'h5)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_detected_speed(i_detected_speed),
    .i_processing_engine_on(i_processing_engine_on),
    .i_chan_input_select(i_chan_input_select), .i_amp_gain(i_amp_gain),
    .i_attenuation(i_attenuation), .i_level_ctrl_on(i_level_ctrl_on),
    .i_samples(i_samples), .i_sample_valid(i_sample_valid), .o_rdata(o_rdata),
    .o_low_power(o_low_power), .o_chan_converter_off(o_chan_converter_off),
    .o_chan_amp_off(o_chan_amp_off), .o_chan_mute(o_chan_mute), .o_path_a(o_path_a),
    .o_path_b(o_path_b), .o_speed(o_speed), .o_master_clock_halve(o_master_clock_halve),
    .o_bit_clock_oe_n(o_bit_clock_oe_n), .o_frame_clock_oe_n(o_frame_clock_oe_n),
    .o_serial_data_oe_n(o_serial_data_oe_n), .o_master_mode(o_master_mode),
    .o_frame_format_i2s(o_frame_format_i2s), .o_output_route(o_output_route),
    .o_chan_preamp_off(o_chan_preamp_off), .o_bias_off(o_bias_off),
    .o_chan_preamp_high_gain(o_chan_preamp_high_gain),
    .o_chan_digital_boost(o_chan_digital_boost), .o_bias_pin_second(o_bias_pin_second),
    .o_bias_level(o_bias_level), .o_amp_gain(o_amp_gain), .o_attenuation(o_attenuation),
    .o_level_ctrl_on(o_level_ctrl_on), .o_samples(o_samples),
    .o_sample_valid(o_sample_valid)
  );

  // ==========================================================
  // access tasks
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(48'(o_rdata), 48'(exp));
  endtask : rdc

  // write then read with no idle cycle between the strobes
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(48'(o_rdata), 48'(d));
  endtask : wrr

  // derived outputs lag their register by one cycle; margin added
  task automatic st;
    repeat (3) @(posedge i_clk);
    #1;
  endtask : st

  task automatic smp(input logic [23:0] a, input logic [23:0] b, input logic [47:0] exp);
    @(posedge i_clk);
    i_samples <= {b, a};
    i_sample_valid <= 1'b1;
    @(posedge i_clk);
    i_sample_valid <= 1'b0;
    #1;
    chk(48'(o_sample_valid), 48'h1);
    chk(48'(o_samples), exp);
  endtask : smp

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // ==========================================================
  // tests
  logic [7:0] rst_v [5] = '{8'h00, 8'hAE, 8'h00, 8'h00, 8'hA0};
  logic [2:0] oe_v [4] = '{3'b110, 3'b111, 3'b000, 3'b111};
  logic [1:0] route_v [4] = '{2'h0, 2'h0, 2'h2, 2'h1};

  initial
  begin
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rdc(8'h01, id_v);
    for (int i = 0; i < 5; i++) rdc(8'h02 + 8'(i), rst_v[i]);
    st;
    chk(48'({o_chan_preamp_off, o_bias_off}), 48'h7);
    chk(48'({o_bit_clock_oe_n, o_serial_data_oe_n, o_master_mode}), 48'h4);
    $display("reset defaults done");
    wr(8'h01, 8'h00);
    rdc(8'h01, id_v);
    wr(8'h07, 8'hFF);
    rdc(8'h07, 8'h00);
    for (int i = 0; i < 5; i++) wr(8'h02 + 8'(i), 8'hA5 ^ 8'(i));
    for (int i = 0; i < 5; i++) rdc(8'h02 + 8'(i), 8'hA5 ^ 8'(i));
    wrr(8'h05, 8'h5A);
    for (int i = 0; i < 5; i++) wr(8'h02 + 8'(i), rst_v[i]);
    wr(8'h04, 8'hB8);
    rdc(8'h04, 8'hB8);
    wr(8'h04, 8'h00);
    $display("access kinds done");
    // reserved power bits held high, as software should
    wr(8'h02, 8'h62);
    st;
    chk(48'({o_chan_mute, o_chan_converter_off}), 48'h4);
    wr(8'h02, 8'h61);
    st;
    chk(48'({o_low_power, o_chan_converter_off, o_chan_amp_off}), 48'h1F);
    rdc(8'h03, 8'hAE);
    wr(8'h02, 8'h63);
    wr(8'h02, 8'h62);
    st;
    chk(48'({o_low_power, o_chan_converter_off, o_chan_mute}), 48'h4);
    wr(8'h02, 8'h68);
    st;
    chk(48'({o_path_a, o_path_b}), 48'h2A);
    wr(8'h02, 8'h60);
    st;
    chk(48'({o_path_a, o_path_b, o_chan_converter_off}), 48'h28);
    $display("power control done");
    chk(48'(o_speed), 48'h3);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h03, {1'b0, 2'(s), 5'h0E});
      st;
      chk(48'(o_speed), 48'(s));
    end
    wr(8'h03, 8'h0F);
    st;
    chk(48'(o_master_clock_halve), 48'h0);
    wr(8'h03, 8'h8F);
    st;
    chk(48'(o_master_clock_halve), 48'h1);
    wr(8'h04, 8'h40);
    wr(8'h03, 8'h2F);
    st;
    chk(48'({o_master_mode, o_master_clock_halve, o_speed}), 48'hD);
    wr(8'h03, 8'hCE);
    st;
    chk(48'(o_speed), 48'h2);
    $display("speed and clock done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h04, i[1] ? 8'h40 : 8'h00);
      wr(8'h03, i[0] ? 8'h3E : 8'h2E);
      st;
      chk(48'({o_bit_clock_oe_n, o_frame_clock_oe_n, o_serial_data_oe_n}), 48'(oe_v[i]));
    end
    wr(8'h03, 8'hA0);
    st;
    chk(48'({o_chan_preamp_off, o_bias_off}), 48'h0);
    $display("serial port float done");
    wr(8'h04, 8'h04);
    st;
    chk(48'(o_frame_format_i2s), 48'h1);
    for (int j = 0; j < 4; j++)
    begin
      @(posedge i_clk);
      i_processing_engine_on <= j[0];
      wr(8'h04, {6'h00, j[1], 1'b0});
      st;
      chk(48'(o_output_route), 48'(route_v[j]));
    end
    smp(24'h000064, 24'h000028, {24'h000028, 24'h000064});
    wr(8'h04, 8'h01);
    st;
    smp(24'h000064, 24'h000028, {2{24'h00001E}});
    smp(24'h000000, 24'h000003, {2{24'hFFFFFE}});
    wr(8'h04, 8'h00);
    $display("format route mix done");
    st;
    chk(48'({o_amp_gain, o_attenuation, o_level_ctrl_on}), {20'h0, 10'h0FA, 16'h33C4, 2'h1});
    wr(8'h05, 8'h80);
    st;
    chk(48'({o_amp_gain, o_attenuation, o_level_ctrl_on}), {20'h0, 10'h35A, 16'hC4C4, 2'h3});
    wr(8'h05, 8'h65);
    st;
    chk(48'({o_chan_preamp_high_gain, o_bias_level, o_bias_pin_second, o_chan_digital_boost}),
      48'h2B);
    wr(8'h05, 8'h1A);
    st;
    chk(48'({o_chan_preamp_high_gain, o_bias_level, o_bias_pin_second, o_chan_digital_boost}),
      48'h54);
    $display("mic control done");
    final_report();
  end

  // ==========================================================
  // watchdog, about forty times the expected run
  initial
  begin
    #100000;
    n_errors++;
    final_report();
  end
endmodule : testbench
